// *** ifl_pkg.sv ***
/*
 * Package for the input fault live status bank: register addresses,
 * flag bit positions, reset values and sizes.
 * Assumes an 8-bit register address and 8-bit data control port.
 */
package ifl_pkg;
    localparam int          IFL_CHANNELS       = 4;
    localparam int          IFL_FLAGS          = 8;
    localparam int          IFL_ADDR_W         = 8;
    localparam int          IFL_DATA_W         = 8;
    localparam int          IFL_SYNC_STAGES    = 2;

    // Register addresses
    localparam logic [7:0]  IFL_ADDR_SUMMARY   = 8'h2D;
    localparam logic [7:0]  IFL_ADDR_CHAN1     = 8'h2E;
    localparam logic [7:0]  IFL_ADDR_CHAN2     = 8'h2F;
    localparam logic [7:0]  IFL_ADDR_CHAN3     = 8'h30;
    localparam logic [7:0]  IFL_ADDR_CHAN4     = 8'h31;

    // Reset values
    localparam logic [7:0]  IFL_RESET_LIVE     = 8'h00;
    localparam logic [7:0]  IFL_RESET_SUMMARY  = 8'h00;
    localparam logic [7:0]  IFL_READ_UNMAPPED  = 8'h00;

    // Flag bit positions inside each channel register
    localparam int          IFL_BIT_OPEN       = 7;
    localparam int          IFL_BIT_PAIR_SHORT = 6;
    localparam int          IFL_BIT_POS_GND    = 5;
    localparam int          IFL_BIT_NEG_GND    = 4;
    localparam int          IFL_BIT_POS_BIAS   = 3;
    localparam int          IFL_BIT_NEG_BIAS   = 2;
    localparam int          IFL_BIT_POS_BAT    = 1;
    localparam int          IFL_BIT_NEG_BAT    = 0;

    // Summary register: channel 1 at bit 7 down to channel 4 at bit 4
    localparam int          IFL_SUM_BIT_CHAN1  = 7;

    typedef logic [IFL_FLAGS-1:0] ifl_flags_t;
endpackage

// *** ifl_sync_if.sv ***
/*
 * Interface carrying detector flags into and out of the synchroniser.
 * Assumes a single control clock on both sides.
 */
`timescale 1ns/1ns
interface ifl_sync_if;
    import ifl_pkg::*;
    ifl_flags_t raw  [IFL_CHANNELS];
    ifl_flags_t sync [IFL_CHANNELS];

    modport src (output raw, input sync);
    modport syn (input raw, output sync);
endinterface

// *** ifl_sync.sv ***
/*
 * Two-stage synchroniser for all detector flag bits.
 * Assumes the detector levels are asynchronous to the control clock.
 */
`timescale 1ns/1ns
module ifl_sync
    import ifl_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   rst,
    ifl_sync_if.syn     port
);
    ifl_flags_t stage1 [IFL_CHANNELS];
    ifl_flags_t stage2 [IFL_CHANNELS];

    genvar ch;
    generate
        for (ch = 0; ch < IFL_CHANNELS; ch++)
        begin : g_chan
            always_ff @(posedge clock)
            begin
                if (rst)
                begin
                    stage1[ch] <= IFL_RESET_LIVE;
                    stage2[ch] <= IFL_RESET_LIVE;
                end
                else
                begin
                    stage1[ch] <= port.raw[ch];
                    stage2[ch] <= stage1[ch];
                end
            end
            assign port.sync[ch] = stage2[ch];
        end
    endgenerate
endmodule

// *** ifl_live_status.sv ***
/*
 * Live input fault status bank for four analog input channels plus the
 * per-channel summary register, read over an 8-bit control port.
 * Assumes the control port presents a read strobe with an address and
 * takes read data one cycle later; detector flags are asynchronous.
 */
// How it works
// R01 - Bit 7 follows the channel open input detector.
// R02 - Bit 6 shows positive and negative inputs shorted together.
// R03 - Bit 5 shows positive input shorted to ground.
// R04 - Bit 4 shows negative input shorted to ground.
// R05 - Bit 3 shows positive input shorted to mic bias rail.
// R06 - Bit 2 shows negative input shorted to mic bias rail.
// R07 - Bit 1 shows positive input shorted to battery rail.
// R08 - Bit 0 shows negative input shorted to battery rail.
// R09 - One means fault detected, zero means none.
// R10 - Channel 2 register read-only at 0x2F, reset zero.
// R11 - Channel 3 register read-only at 0x30, reset zero.
// R12 - Channel 4 register read-only at 0x31, reset zero.
// R13 - Channel 1 register read-only at 0x2E, reset zero.
// R14 - Summary at 0x2D: bits 7..4 set when channel 1..4 has any fault.
// R15 - Flags follow detectors without latching; writes are ignored.
`timescale 1ns/1ns
module ifl_live_status
    import ifl_pkg::*;
(
    input  wire logic                     clock,
    input  wire logic                     rst,
    input  wire logic [IFL_FLAGS-1:0]     det_open_input      [IFL_CHANNELS],
    input  wire logic [IFL_CHANNELS-1:0]  det_pair_short,
    input  wire logic [IFL_CHANNELS-1:0]  det_pos_short_gnd,
    input  wire logic [IFL_CHANNELS-1:0]  det_neg_short_gnd,
    input  wire logic [IFL_CHANNELS-1:0]  det_pos_short_bias,
    input  wire logic [IFL_CHANNELS-1:0]  det_neg_short_bias,
    input  wire logic [IFL_CHANNELS-1:0]  det_pos_short_bat,
    input  wire logic [IFL_CHANNELS-1:0]  det_neg_short_bat,
    input  wire logic                     reg_read,
    input  wire logic                     reg_write,
    input  wire logic [IFL_ADDR_W-1:0]    reg_addr,
    input  wire logic [IFL_DATA_W-1:0]    reg_wdata,
    output logic      [IFL_DATA_W-1:0]    reg_rdata,
    output logic                          reg_rvalid
);
    import ifl_pkg::*;

    ifl_sync_if sync_bus ();
    ifl_flags_t live      [IFL_CHANNELS];
    logic [7:0] summary;
    logic [7:0] next_rdata;

    // ****************************************************
    // Detector flag assembly
    // ****************************************************
    genvar ch;
    generate
        for (ch = 0; ch < IFL_CHANNELS; ch++)
        begin : g_pack
            always_comb
            begin
                sync_bus.raw[ch] = IFL_RESET_LIVE;
                // R01 open input flag
                sync_bus.raw[ch][IFL_BIT_OPEN]       = det_open_input[ch][0];
                // R02 pair short flag
                sync_bus.raw[ch][IFL_BIT_PAIR_SHORT] = det_pair_short[ch];
                // R03 positive ground short
                sync_bus.raw[ch][IFL_BIT_POS_GND]    = det_pos_short_gnd[ch];
                // R04 negative ground short
                sync_bus.raw[ch][IFL_BIT_NEG_GND]    = det_neg_short_gnd[ch];
                // R05 positive bias short
                sync_bus.raw[ch][IFL_BIT_POS_BIAS]   = det_pos_short_bias[ch];
                // R06 negative bias short
                sync_bus.raw[ch][IFL_BIT_NEG_BIAS]   = det_neg_short_bias[ch];
                // R07 positive battery short
                sync_bus.raw[ch][IFL_BIT_POS_BAT]    = det_pos_short_bat[ch];
                // R08 negative battery short
                sync_bus.raw[ch][IFL_BIT_NEG_BAT]    = det_neg_short_bat[ch];
            end

            // R15 live, no latching
            assign live[ch] = sync_bus.sync[ch];

            // R14 summary bit per channel
            assign summary[IFL_SUM_BIT_CHAN1-ch] = |live[ch];
        end
    endgenerate

    assign summary[3:0] = 4'h0;

    ifl_sync u_sync
    (
        .clock (clock),
        .rst   (rst),
        .port  (sync_bus.syn)
    );

    // ****************************************************
    // Register read decode
    // ****************************************************
    always_comb
    begin
        // R09 active high flags
        if (reg_addr == IFL_ADDR_SUMMARY)
            next_rdata = summary;
        // R13 channel 1 read
        else if (reg_addr == IFL_ADDR_CHAN1)
            next_rdata = live[0];
        // R10 channel 2 read
        else if (reg_addr == IFL_ADDR_CHAN2)
            next_rdata = live[1];
        // R11 channel 3 read
        else if (reg_addr == IFL_ADDR_CHAN3)
            next_rdata = live[2];
        // R12 channel 4 read
        else if (reg_addr == IFL_ADDR_CHAN4)
            next_rdata = live[3];
        else
            next_rdata = IFL_READ_UNMAPPED;
    end

    // R15 writes ignored
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            reg_rdata  <= IFL_RESET_LIVE;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_read;
            if (reg_read)
                reg_rdata <= next_rdata;
        end
    end
endmodule

// *** ifl_chk.sv ***
/* Concurrent checks on the live fault bank ports.
   Bound into ifl_live_status; one clock, synchronous reset. */
`timescale 1ns/1ns
module ifl_chk
    import ifl_pkg::*;
(
    input wire logic                    clock,
    input wire logic                    rst,
    input wire logic [IFL_FLAGS-1:0]    det_open_input [IFL_CHANNELS],
    input wire logic [IFL_CHANNELS-1:0] det_pair_short,
    input wire logic [IFL_CHANNELS-1:0] det_pos_short_gnd,
    input wire logic [IFL_CHANNELS-1:0] det_neg_short_gnd,
    input wire logic [IFL_CHANNELS-1:0] det_pos_short_bias,
    input wire logic [IFL_CHANNELS-1:0] det_neg_short_bias,
    input wire logic [IFL_CHANNELS-1:0] det_pos_short_bat,
    input wire logic [IFL_CHANNELS-1:0] det_neg_short_bat,
    input wire logic                    reg_read,
    input wire logic                    reg_write,
    input wire logic [IFL_ADDR_W-1:0]   reg_addr,
    input wire logic [IFL_DATA_W-1:0]   reg_wdata,
    input wire logic [IFL_DATA_W-1:0]   reg_rdata,
    input wire logic                    reg_rvalid
);
// ********
// Checks
// ********
default clocking @(posedge clock);
endclocking
default disable iff (rst);
sequence open_quiet;
    (!rst && $stable(det_open_input[0][0])) [*3];
endsequence
sequence bat4_quiet;
    (!rst && $stable(det_neg_short_bat[3])) [*3];
endsequence
rd_answer_a: assert property (reg_read |=> reg_rvalid) else $error("read not answered");
rvalid_pulse_a: assert property (!reg_read |=> !reg_rvalid) else $error("stray rvalid");
rdata_hold_a: assert property (!reg_read |=> $stable(reg_rdata)) else $error("rdata moved");
reset_zero_a: assert property ($past(rst) |-> reg_rdata == 8'h00 && !reg_rvalid) else $error("reset value");
unmapped_zero_a: assert property (reg_read && (reg_addr < 8'h2D || reg_addr > 8'h31) |=> reg_rdata == 8'h00)
    else $error("unmapped data");
sum_low_a: assert property (reg_read && reg_addr == IFL_ADDR_SUMMARY |=> reg_rdata[3:0] == 4'h0)
    else $error("summary low bits");
open_bit_a: assert property (open_quiet ##0 (reg_read && reg_addr == IFL_ADDR_CHAN1)
    |=> reg_rdata[7] == $past(det_open_input[0][0])) else $error("open flag");
bat4_bit_a: assert property (bat4_quiet ##0 (reg_read && reg_addr == IFL_ADDR_CHAN4)
    |=> reg_rdata[0] == $past(det_neg_short_bat[3])) else $error("battery flag");
endmodule
bind ifl_live_status ifl_chk u_chk (.*);

// *** tb.sv ***
/* Self-checking bench for the live fault bank.
   Drives ports at the falling edge; model mirrors the register map. */
`timescale 1ns/1ns
module tb;
    import ifl_pkg::*;
    logic clock = 0, rst = 1, reg_read = 0, reg_write = 0, reg_rvalid;
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, fl [4], det_open_input [4];
    logic [3:0] det_pair_short, det_pos_short_gnd, det_neg_short_gnd, det_pos_short_bias;
    logic [3:0] det_neg_short_bias, det_pos_short_bat, det_neg_short_bat;
    logic [31:0] lfsr = 92645;
    int bad_count = 0, num_checks = 0, cyc = 0;
    ifl_live_status u_dut (.*);
    initial forever #20 clock = ~clock;
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            close_out();
        end
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [7:0] model(input logic [7:0] a);
        logic [7:0] s = 8'h00;
        for (int c = 0; c < 4; c++) s[7-c] = |fl[c];
        if (a == IFL_ADDR_SUMMARY) return s;
        if (a >= IFL_ADDR_CHAN1 && a <= IFL_ADDR_CHAN4) return fl[a-IFL_ADDR_CHAN1];
        return 8'h00;
    endfunction
    task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task apply;
        for (int c = 0; c < 4; c++)
        begin
            {det_open_input[c][0], det_pair_short[c], det_pos_short_gnd[c], det_neg_short_gnd[c],
             det_pos_short_bias[c], det_neg_short_bias[c], det_pos_short_bat[c], det_neg_short_bat[c]} = fl[c];
            det_open_input[c][7:1] = lfsr[7:1];
        end
        repeat (4) @(negedge clock);
    endtask
    task sweep;
        for (logic [7:0] a = 8'h2C; a < 8'h33; a++)
        begin
            reg_read = 1;
            reg_addr = a;
            @(negedge clock);
            chk("rdata", reg_rdata, model(a));
            chk("rvalid", {7'h00, reg_rvalid}, 8'h01);
        end
        reg_read = 0;
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        for (int c = 0; c < 4; c++) fl[c] = 8'h00;
        apply();
        repeat (6) @(negedge clock);
        rst = 0;
        sweep();
        $display("reset test done");
        for (int k = 0; k < 32; k++)
        begin
            for (int c = 0; c < 4; c++) fl[c] = (c == k / 8) ? 8'h01 << (k % 8) : 8'h00;
            apply();
            sweep();
        end
        $display("bit walk test done");
        repeat (30)
        begin
            for (int c = 0; c < 4; c++)
            begin
                lfsr = lfsr_next(lfsr);
                fl[c] = lfsr[15:8];
            end
            reg_write = 1;
            reg_wdata = lfsr[23:16];
            apply();
            sweep();
            reg_write = 0;
        end
        $display("random test done");
        close_out();
    end
endmodule
